// *** rtl/agu_ext_pkg.sv ***
// package for the address-generation extensions: control fields, address
// widths, instruction classes and the pipeline-facing carriers.
// assumes a single core clock domain; no timing constants are needed.
package agu_ext_pkg;

	// ----------------------------------------------------------------
	// control register fields and reset values
	// ----------------------------------------------------------------
	localparam int          BITREV_EN_BIT      = 15;              // enable bit in bitrev control
	localparam int          PIVOT_MSB          = 14;              // pivot field top bit
	localparam int          PTR_SEL_LSB        = 8;               // pointer select in mode control
	localparam int          PTR_SEL_MSB        = 11;
	localparam logic [3:0]  PTR_SEL_NONE       = 4'hF;            // pointer 15: reversal off
	localparam int          VIS_EN_BIT         = 2;               // visibility enable in core control
	localparam int          CFG_SPACE_BIT      = 7;               // table page config select bit
	localparam logic [15:0] BITREV_CTRL_RESET  = 16'h0000;
	localparam logic [15:0] MODE_CTRL_RESET    = 16'h0FFF;
	localparam logic [15:0] CORE_CTRL_RESET    = 16'h0000;
	localparam logic [7:0]  TABLE_PAGE_RESET   = 8'h00;
	localparam logic [7:0]  VIS_PAGE_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// register port offsets (word offsets on the plain port)
	// ----------------------------------------------------------------
	localparam logic [3:0]  OFS_BITREV_CTRL    = 4'h0;
	localparam logic [3:0]  OFS_MODE_CTRL      = 4'h1;
	localparam logic [3:0]  OFS_CORE_CTRL      = 4'h2;
	localparam logic [3:0]  OFS_TABLE_PAGE     = 4'h3;
	localparam logic [3:0]  OFS_VIS_PAGE       = 4'h4;
	localparam logic [3:0]  OFS_STATUS         = 4'h5;

	// ----------------------------------------------------------------
	// extra cycle counts for visibility accesses, and the program counter step
	// ----------------------------------------------------------------
	localparam logic [1:0]  VIS_EXTRA_MOVE     = 2'h1;
	localparam logic [1:0]  VIS_EXTRA_OTHER    = 2'h2;
	localparam logic [1:0]  VIS_EXTRA_REPEAT   = 2'h0;
	localparam logic [23:0] PC_STEP            = 24'h000002;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		AM_DIRECT    = 3'b000,
		AM_INDIRECT  = 3'b001,
		AM_POST_INC  = 3'b010,
		AM_PRE_INC   = 3'b011,
		AM_POST_DEC  = 3'b100,
		AM_PRE_DEC   = 3'b101,
		AM_OFFSET    = 3'b110
	} addr_mode_t;

	typedef enum logic [2:0] {
		TOP_NONE       = 3'b000,
		TOP_READ_LOW   = 3'b001,
		TOP_READ_HIGH  = 3'b010,
		TOP_WRITE_LOW  = 3'b011,
		TOP_WRITE_HIGH = 3'b100
	} table_op_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_STALL = 2'b01
	} stall_state_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;      // write access present
		logic [3:0]  ptr_idx;    // pointer register number
		logic [15:0] ptr_val;    // pointer value
		addr_mode_t  mode;       // addressing mode
		logic [15:0] offset;     // normal mode increment (signed)
		logic        byte_op;    // byte sized write
	} xw_req_t;

	typedef struct packed {
		logic        valid;
		table_op_t   op;
		logic [15:0] ea;
		logic        byte_op;
	} tbl_req_t;

	typedef struct packed {
		logic        valid;      // data read issued
		logic [15:0] ea;
		logic        is_move;    // plain or double move instruction
		logic        in_repeat;  // inside a repeat loop
		logic        rpt_edge;   // first/last/interrupt exit/re-entry iteration
	} rd_req_t;

endpackage : agu_ext_pkg

// *** rtl/bitrev_adder.sv ***
// reverse-carry adder used by the bit-reversed write address path.
// purely combinational; caller registers the result.
`timescale 1ns/1ps

module bitrev_adder #(
	parameter int W = 16
) (
	a,
	b,
	sum
);
	input  wire logic [W-1:0] a;   // pointer
	input  wire logic [W-1:0] b;   // scaled pivot
	output      logic [W-1:0] sum; // reverse-carry sum

	// ----------------------------------------------------------------
	// carry ripples from msb down to lsb
	// ----------------------------------------------------------------
	always_comb begin
		logic c;
		c = 1'b0;
		for (int i = W - 1; i >= 0; i--) begin
			sum[i] = a[i] ^ b[i] ^ c;
			c      = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
		end
	end

endmodule // bitrev_adder

// *** rtl/agu_ext.sv ***
// address-generation extensions: bit-reversed x write addresses,
// table and visibility program addresses, read data steering, stall counts.
// assumes pipeline requests are synchronous to mclk, one cycle each.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps

module agu_ext (
	mclk,
	rst_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	xw_req,
	modulo_en_x,
	xw_addr,
	xw_ptr_next,
	xw_bitrev_used,
	xw_modulo_allow,
	xr_modulo_allow,
	tbl_req,
	rd_req,
	prog_addr,
	prog_cfg_space,
	prog_rd,
	prog_rdata,
	rd_data,
	vis_active,
	stall,
	pc_advance,
	pc_q_out
);
	input  wire logic                      mclk;            // core clock
	input  wire logic                      rst_n;           // async reset, low
	input  wire logic [3:0]                reg_addr;        // register offset
	input  wire logic [15:0]               reg_wdata;       // write data
	input  wire logic                      reg_wr;          // write strobe
	input  wire logic                      reg_rd;          // read strobe
	output      logic [15:0]               reg_rdata;       // read data, next cycle
	input  wire agu_ext_pkg::xw_req_t      xw_req;          // x write request
	input  wire logic                      modulo_en_x;     // modulo on for x pointer
	output      logic [15:0]               xw_addr;         // registered write ea
	output      logic [15:0]               xw_ptr_next;     // registered pointer update
	output      logic                      xw_bitrev_used;  // last write used reversal
	output      logic                      xw_modulo_allow; // modulo may act on x write
	output      logic                      xr_modulo_allow; // modulo may act on x read
	input  wire agu_ext_pkg::tbl_req_t     tbl_req;         // table operation
	input  wire agu_ext_pkg::rd_req_t      rd_req;          // data read
	output      logic [23:0]               prog_addr;       // program memory address
	output      logic                      prog_cfg_space;  // configuration memory select
	output      logic                      prog_rd;         // program fetch strobe
	input  wire logic [23:0]               prog_rdata;      // program word, same cycle as the strobe
	output      logic [15:0]               rd_data;         // steered read data
	output      logic                      vis_active;      // remapped read in flight
	output      logic                      stall;           // hold the pipeline
	input  wire logic                      pc_advance;      // step program counter
	output      logic [23:0]               pc_q_out;        // program counter

	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	// short alias keeps the record readable
	typedef agu_ext_pkg::table_op_t table_op_t_l;
	typedef struct packed {
		logic [15:0]               bitrev_ctrl;   // enable and pivot
		logic [15:0]               mode_ctrl;     // pointer select lives here
		logic [15:0]               core_ctrl;     // visibility enable
		logic [7:0]                table_page;
		logic [7:0]                vis_page;
		logic [15:0]               rdata;
		logic [15:0]               xw_addr;
		logic [15:0]               xw_ptr;
		logic                      xw_brev;
		logic [23:0]               prog_addr;
		logic                      cfg;
		logic                      prog_rd;
		table_op_t_l               pend_op;       // table read awaiting data
		logic                      pend_byte;
		logic                      pend_bsel;
		logic                      pend_vis;      // visibility read awaiting data
		logic [15:0]               rd_data;
		agu_ext_pkg::stall_state_t st;
		logic [1:0]                extra;         // remaining stall cycles
		logic [23:0]               pc;
	} state_t;

	state_t q_q;
	state_t q_d;

	// ----------------------------------------------------------------
	// combinational helpers
	// ----------------------------------------------------------------
	logic        ptr_ok;        // pointer select not 15 and matches
	logic        brev_en;       // enable bit set
	logic        inc_mode;      // pre or post increment
	logic        brev_act;      // reversal applies to this write
	logic [15:0] pivot_bytes;   // pivot scaled to byte address
	logic [15:0] brev_sum;      // reverse-carry sum
	logic        tbl_busy;      // table op in this or pending cycle
	logic        vis_hit;       // remap this read

	assign pivot_bytes = {q_q.bitrev_ctrl[agu_ext_pkg::PIVOT_MSB:0], 1'b0};

	assign ptr_ok   = (q_q.mode_ctrl[agu_ext_pkg::PTR_SEL_MSB:agu_ext_pkg::PTR_SEL_LSB]
	                   != agu_ext_pkg::PTR_SEL_NONE)
	               && (q_q.mode_ctrl[agu_ext_pkg::PTR_SEL_MSB:agu_ext_pkg::PTR_SEL_LSB]
	                   == xw_req.ptr_idx);
	assign brev_en  = q_q.bitrev_ctrl[agu_ext_pkg::BITREV_EN_BIT];
	assign inc_mode = (xw_req.mode == agu_ext_pkg::AM_PRE_INC) || (xw_req.mode == agu_ext_pkg::AM_POST_INC);
	assign brev_act = xw_req.valid && ptr_ok && brev_en && inc_mode && !xw_req.byte_op;

	assign xw_modulo_allow = modulo_en_x && !(ptr_ok && brev_en);
	assign xr_modulo_allow = modulo_en_x;

	bitrev_adder #(
		.W(16)
	) u_adder (
		.a   (xw_req.ptr_val),
		.b   (pivot_bytes),
		.sum (brev_sum)
	);

	assign tbl_busy = (tbl_req.valid && tbl_req.op != agu_ext_pkg::TOP_NONE)
	               || (q_q.pend_op != agu_ext_pkg::TOP_NONE);
	assign vis_hit  = rd_req.valid && rd_req.ea[15] && q_q.core_ctrl[agu_ext_pkg::VIS_EN_BIT] && !tbl_busy;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [15:0] nrm_addr;
		logic [15:0] nrm_ptr;
		logic [15:0] word;
		q_d      = q_q;
		nrm_addr = 16'h0000;
		nrm_ptr  = 16'h0000;
		word     = 16'h0000;
		q_d.prog_rd = 1'b0;
		q_d.pend_op = agu_ext_pkg::TOP_NONE;
		q_d.pend_vis = 1'b0;

		// register writes
		if (reg_wr) begin
			if (reg_addr == agu_ext_pkg::OFS_BITREV_CTRL) begin
				q_d.bitrev_ctrl = reg_wdata;
			end else if (reg_addr == agu_ext_pkg::OFS_MODE_CTRL) begin
				q_d.mode_ctrl = reg_wdata;
			end else if (reg_addr == agu_ext_pkg::OFS_CORE_CTRL) begin
				q_d.core_ctrl = reg_wdata;
			end else if (reg_addr == agu_ext_pkg::OFS_TABLE_PAGE) begin
				q_d.table_page = reg_wdata[7:0];
			end else if (reg_addr == agu_ext_pkg::OFS_VIS_PAGE) begin
				q_d.vis_page = reg_wdata[7:0];
			end
		end

		// register reads, unmapped reads zero
		if (reg_rd) begin
			if (reg_addr == agu_ext_pkg::OFS_BITREV_CTRL) begin
				q_d.rdata = q_q.bitrev_ctrl;
			end else if (reg_addr == agu_ext_pkg::OFS_MODE_CTRL) begin
				q_d.rdata = q_q.mode_ctrl;
			end else if (reg_addr == agu_ext_pkg::OFS_CORE_CTRL) begin
				q_d.rdata = q_q.core_ctrl;
			end else if (reg_addr == agu_ext_pkg::OFS_TABLE_PAGE) begin
				q_d.rdata = {8'h00, q_q.table_page};
			end else if (reg_addr == agu_ext_pkg::OFS_VIS_PAGE) begin
				q_d.rdata = {8'h00, q_q.vis_page};
			end else if (reg_addr == agu_ext_pkg::OFS_STATUS) begin
				q_d.rdata = {12'h000, q_q.st == agu_ext_pkg::ST_STALL, q_q.pend_vis,
				             q_q.cfg, q_q.xw_brev};
			end else begin
				q_d.rdata = 16'h0000;
			end
		end

		// x write address generation
		if (xw_req.valid) begin
			nrm_ptr  = xw_req.ptr_val + xw_req.offset;
			nrm_addr = (xw_req.mode == agu_ext_pkg::AM_PRE_INC || xw_req.mode == agu_ext_pkg::AM_PRE_DEC)
			           ? nrm_ptr : xw_req.ptr_val;
			if (brev_act) begin
				q_d.xw_ptr  = {brev_sum[15:1], 1'b0};
				q_d.xw_addr = (xw_req.mode == agu_ext_pkg::AM_PRE_INC) ? {brev_sum[15:1], 1'b0}
				              : {xw_req.ptr_val[15:1], 1'b0};
				q_d.xw_brev = 1'b1;
			end else begin
				q_d.xw_ptr  = (xw_req.mode == agu_ext_pkg::AM_DIRECT || xw_req.mode == agu_ext_pkg::AM_INDIRECT
				               || xw_req.mode == agu_ext_pkg::AM_OFFSET) ? xw_req.ptr_val : nrm_ptr;
				q_d.xw_addr = (xw_req.mode == agu_ext_pkg::AM_OFFSET) ? nrm_ptr : nrm_addr;
				q_d.xw_brev = 1'b0;
			end
		end

		// program space addressing
		if (tbl_req.valid && tbl_req.op != agu_ext_pkg::TOP_NONE) begin
			q_d.prog_addr = {q_q.table_page, tbl_req.ea};
			q_d.cfg       = q_q.table_page[agu_ext_pkg::CFG_SPACE_BIT];
			q_d.prog_rd   = (tbl_req.op == agu_ext_pkg::TOP_READ_LOW) || (tbl_req.op == agu_ext_pkg::TOP_READ_HIGH);
			q_d.pend_op   = q_d.prog_rd ? tbl_req.op : agu_ext_pkg::TOP_NONE;
			q_d.pend_byte = tbl_req.byte_op;
			q_d.pend_bsel = tbl_req.ea[0];
		end else if (vis_hit) begin
			q_d.prog_addr = {1'b0, q_q.vis_page, rd_req.ea[14:0]};
			q_d.cfg       = 1'b0;
			q_d.prog_rd   = 1'b1;
			q_d.pend_vis  = 1'b1;
		end

		// read data steering
		word = prog_rdata[15:0];
		if (q_q.pend_op == agu_ext_pkg::TOP_READ_LOW) begin
			if (!q_q.pend_byte) begin
				q_d.rd_data = word;
			end else if (q_q.pend_bsel) begin
				q_d.rd_data = {8'h00, word[15:8]};
			end else begin
				q_d.rd_data = {8'h00, word[7:0]};
			end
		end else if (q_q.pend_op == agu_ext_pkg::TOP_READ_HIGH) begin
			if (q_q.pend_byte && q_q.pend_bsel) begin
				q_d.rd_data = 16'h0000;
			end else begin
				q_d.rd_data = {8'h00, prog_rdata[23:16]};
			end
		end else if (q_q.pend_vis) begin
			q_d.rd_data = word;
		end

		// stall sequencing
		case (q_q.st)
			agu_ext_pkg::ST_IDLE: begin
				if (vis_hit) begin
					if (rd_req.in_repeat && !rd_req.rpt_edge) begin
						q_d.extra = agu_ext_pkg::VIS_EXTRA_REPEAT;
					end else if (rd_req.in_repeat || !rd_req.is_move) begin
						q_d.extra = agu_ext_pkg::VIS_EXTRA_OTHER;
					end else begin
						q_d.extra = agu_ext_pkg::VIS_EXTRA_MOVE;
					end
					q_d.st = (q_d.extra != 2'h0) ? agu_ext_pkg::ST_STALL : agu_ext_pkg::ST_IDLE;
				end
			end
			agu_ext_pkg::ST_STALL: begin
				q_d.extra = q_q.extra - 2'h1;
				if (q_q.extra == 2'h1) begin
					q_d.st = agu_ext_pkg::ST_IDLE;
				end
			end
			default: begin
				q_d.st = agu_ext_pkg::ST_IDLE;
			end
		endcase

		if (pc_advance) begin
			q_d.pc = q_q.pc + agu_ext_pkg::PC_STEP;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_q             <= '0;
			q_q.bitrev_ctrl <= agu_ext_pkg::BITREV_CTRL_RESET;
			q_q.mode_ctrl   <= agu_ext_pkg::MODE_CTRL_RESET;
			q_q.core_ctrl   <= agu_ext_pkg::CORE_CTRL_RESET;
			q_q.table_page  <= agu_ext_pkg::TABLE_PAGE_RESET;
			q_q.vis_page    <= agu_ext_pkg::VIS_PAGE_RESET;
			q_q.pend_op     <= agu_ext_pkg::TOP_NONE;
			q_q.st          <= agu_ext_pkg::ST_IDLE;
		end else begin
			q_q <= q_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata      = q_q.rdata;
	assign xw_addr        = q_q.xw_addr;
	assign xw_ptr_next    = q_q.xw_ptr;
	assign xw_bitrev_used = q_q.xw_brev;
	assign prog_addr      = q_q.prog_addr;
	assign prog_cfg_space = q_q.cfg;
	assign prog_rd        = q_q.prog_rd;
	assign rd_data        = q_q.rd_data;
	assign vis_active     = q_q.pend_vis;
	// stall covers only the counted extras, the first of them in the cycle the remapped data returns
	assign stall          = (q_q.st == agu_ext_pkg::ST_STALL);
	assign pc_q_out       = q_q.pc;

endmodule // agu_ext

// *** verif/agu_ext_assertions.sv ***
// checker for the address-generation extensions, bound to agu_ext
// assumes one core clock and the asynchronous active-low reset
`timescale 1ns/1ps
module agu_ext_checker (
	input wire logic                  mclk,
	input wire logic                  rst_n,
	input wire agu_ext_pkg::xw_req_t  xw_req,
	input wire logic [15:0]           xw_addr,
	input wire logic [15:0]           xw_ptr_next,
	input wire logic                  xw_bitrev_used,
	input wire agu_ext_pkg::tbl_req_t tbl_req,
	input wire agu_ext_pkg::rd_req_t  rd_req,
	input wire logic [23:0]           prog_addr,
	input wire logic                  prog_cfg_space,
	input wire logic                  prog_rd,
	input wire logic [23:0]           prog_rdata,
	input wire logic [15:0]           rd_data,
	input wire logic                  vis_active,
	input wire logic                  stall,
	input wire logic                  pc_advance,
	input wire logic [23:0]           pc_q_out
);
	logic tbl_go; // a table operation taken this cycle
	logic no_inc; // write request that may not reverse
	assign tbl_go = tbl_req.valid && tbl_req.op != agu_ext_pkg::TOP_NONE;
	assign no_inc = xw_req.byte_op || !(xw_req.mode inside {agu_ext_pkg::AM_POST_INC, agu_ext_pkg::AM_PRE_INC});
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	tbl_addr_a: assert property (tbl_go |=> prog_addr[15:0] == $past(tbl_req.ea))
		else $error("table address low word wrong");
	cfg_space_a: assert property (tbl_go |=> prog_cfg_space == prog_addr[23])
		else $error("configuration select wrong");
	vis_addr_a: assert property (vis_active |-> prog_rd && !prog_addr[23] && prog_addr[14:0] == $past(rd_req.ea[14:0]))
		else $error("visibility address wrong");
	vis_data_a: assert property (vis_active |=> rd_data == $past(prog_rdata[15:0]))
		else $error("visibility data wrong");
	vis_gate_a: assert property (rd_req.valid && !rd_req.ea[15] |=> !vis_active)
		else $error("remap without address msb");
	tbl_suspend_a: assert property (tbl_go |=> !vis_active)
		else $error("remap during table operation");
	high_phantom_a: assert property ((tbl_go && tbl_req.op == agu_ext_pkg::TOP_READ_HIGH && !tbl_req.byte_op) ##2 1
		|-> rd_data == {8'h00, $past(prog_rdata[23:16])}) else $error("high read data wrong");
	pc_step_a: assert property (pc_advance |=> pc_q_out == $past(pc_q_out) + 24'h000002)
		else $error("program counter step wrong");
	byte_normal_a: assert property (xw_req.valid && no_inc |=> !xw_bitrev_used)
		else $error("reversal on byte or other mode");
	brev_lsb_a: assert property (xw_bitrev_used |-> !xw_ptr_next[0] && !xw_addr[0])
		else $error("reversed address lsb set");
	move_stall_a: assert property (vis_active && $past(rd_req.is_move && !rd_req.in_repeat) |-> stall ##1 !stall)
		else $error("move stall length wrong");
	other_stall_a: assert property (vis_active && $past(!rd_req.is_move && !rd_req.in_repeat) |-> stall[*2] ##1 !stall)
		else $error("other stall length wrong");
	rpt_mid_a: assert property (vis_active && $past(rd_req.in_repeat && !rd_req.rpt_edge) |-> !stall)
		else $error("repeat middle stalled");
	cover property (vis_active && stall);
	cover property (xw_bitrev_used);
	cover property (tbl_go ##1 prog_cfg_space);
endmodule // agu_ext_checker

bind agu_ext agu_ext_checker chk_i (.mclk, .rst_n, .xw_req, .xw_addr, .xw_ptr_next, .xw_bitrev_used, .tbl_req, .rd_req,
	.prog_addr, .prog_cfg_space, .prog_rd, .prog_rdata, .rd_data, .vis_active, .stall, .pc_advance, .pc_q_out);

// *** verif/prog_mem_model.sv ***
// program memory model: answers a fetch in the cycle of the strobe
// assumes the block holds address and strobe for that one cycle
`timescale 1ns/1ps
module prog_mem_model (
	input wire logic        mclk,
	input wire logic [23:0] prog_addr,
	input wire logic        prog_rd,
	output     logic [23:0] prog_rdata
);
	logic [23:0] junk_q = 24'h5A5A5A; // idle bus pattern, flips every cycle
	// word content is a fixed mix of its address
	function automatic logic [23:0] word(input logic [23:0] a);
		return {a[7:0] ^ a[23:16], a[15:0] ^ 16'hA55A};
	endfunction
	always_ff @(posedge mclk) begin
		junk_q <= ~junk_q;
	end
	// bus carries the flipping idle pattern outside a fetch
	assign prog_rdata = prog_rd ? word(prog_addr) : junk_q;
endmodule // prog_mem_model

// *** verif/tb.sv ***
// self-checking bench for agu_ext with a program memory model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module tb;
	logic                  mclk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [3:0]            reg_addr = 4'h0;
	logic [15:0]           reg_wdata = 16'h0000;
	logic                  reg_wr = 1'b0;
	logic                  reg_rd = 1'b0;
	logic                  modulo_en_x = 1'b1; // modulo also requested
	logic                  pc_advance = 1'b0;
	agu_ext_pkg::xw_req_t  xw_req = '0;
	agu_ext_pkg::tbl_req_t tbl_req = '0;
	agu_ext_pkg::rd_req_t  rd_req = '0;
	agu_ext_pkg::addr_mode_t m;
	agu_ext_pkg::table_op_t op;
	logic [15:0]           reg_rdata, xw_addr, xw_ptr_next, rd_data, v, piv, p, np, ea;
	logic                  xw_bitrev_used, xw_modulo_allow, xr_modulo_allow, prog_cfg_space, prog_rd, vis_active, stall;
	logic                  b, act, vis;
	logic [3:0]            idx;
	logic [23:0]           prog_addr, prog_rdata, pc_q_out, w;
	logic [31:0]           seed = 32'h000082BA;
	int                    fail_count = 0, total_checks = 0, cycles = 0, n;

	always #2.5 mclk = ~mclk;
	agu_ext dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xw_req, .modulo_en_x, .xw_addr,
		.xw_ptr_next, .xw_bitrev_used, .xw_modulo_allow, .xr_modulo_allow, .tbl_req, .rd_req, .prog_addr,
		.prog_cfg_space, .prog_rd, .prog_rdata, .rd_data, .vis_active, .stall, .pc_advance, .pc_q_out);
	prog_mem_model mem (.mclk, .prog_addr, .prog_rd, .prog_rdata);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// reverse-carry add: carries run from high bits down
	function automatic logic [15:0] revc(input logic [15:0] a, input logic [15:0] c);
		logic [15:0] ra, rc, s;
		ra = {<<{a}};
		rc = {<<{c}};
		s  = ra + rc;
		ra = {<<{s}};
		return ra;
	endfunction
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// one-cycle write request; modulo gating seen while it stands
	task automatic xw_go();
		@(posedge mclk);
		xw_req <= '{1'b1, idx, p, m, 16'h0002, b};
		#1;
		if (act) begin
			chk(xw_modulo_allow, 1'b0);
		end else if (idx == 4'hF) begin
			chk(xw_modulo_allow, modulo_en_x);
		end
		chk(xr_modulo_allow, modulo_en_x);
		@(posedge mclk);
		xw_req.valid <= 1'b0;
		#1;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd_reg(agu_ext_pkg::OFS_MODE_CTRL);
		chk(v, 16'h0FFF);
		rd_reg(4'hC);
		chk(v, 16'h0000);
		// bit-reversed writes: enabled, disabled, pointer select 15
		for (int ph = 0; ph < 3; ph++) begin
			wr_reg(agu_ext_pkg::OFS_MODE_CTRL, (ph == 2) ? 16'h0F00 : 16'h0300);
			for (int j = 0; j < 3; j++) begin
				piv = (j == 0) ? 16'h0001 : ((j == 1) ? 16'h0010 : 16'h4000);
				modulo_en_x <= (j != 1);
				wr_reg(agu_ext_pkg::OFS_BITREV_CTRL, {ph != 1, piv[14:0]});
				for (int i = 0; i < 10; i++) begin
					m = (i < 7) ? agu_ext_pkg::addr_mode_t'(i) : ((i == 9) ? agu_ext_pkg::AM_PRE_INC : agu_ext_pkg::AM_POST_INC);
					b = (i == 7);
					idx = (ph == 2) ? 4'hF : ((i == 8) ? 4'h2 : 4'h3);
					p = 16'(rnd()) & ~16'((32'(piv) << 2) - 1);
					p = p | (16'(rnd()) & 16'((32'(piv) << 2) - 2)); // walk inside the aligned buffer
					act = ph == 0 && idx == 4'h3 && !b && m inside {agu_ext_pkg::AM_POST_INC, agu_ext_pkg::AM_PRE_INC};
					xw_go();
					chk(xw_bitrev_used, act);
					if (act) begin
						np = revc(p, {piv[14:0], 1'b0}) & 16'hFFFE;
						chk(xw_ptr_next, np);
						chk(xw_addr, (m == agu_ext_pkg::AM_POST_INC) ? p : np);
					end else if (m inside {agu_ext_pkg::AM_POST_INC, agu_ext_pkg::AM_PRE_INC}) begin
						chk(xw_ptr_next, 16'(p + 16'h0002));
						chk(xw_addr, (m == agu_ext_pkg::AM_POST_INC) ? p : 16'(p + 16'h0002));
					end
				end
			end
		end
		// table operations, both memory spaces, word and byte
		for (int pg = 0; pg < 2; pg++) begin
			wr_reg(agu_ext_pkg::OFS_TABLE_PAGE, (pg == 1) ? 16'h0085 : 16'h0012);
			for (int k = 1; k < 9; k++) begin
				op = agu_ext_pkg::table_op_t'((k + 1) / 2);
				b = k[0];
				ea = 16'(rnd());
				@(posedge mclk);
				tbl_req <= '{1'b1, op, ea, b};
				@(posedge mclk);
				tbl_req.valid <= 1'b0;
				#1 w = {(pg == 1) ? 8'h85 : 8'h12, ea};
				chk(prog_addr, w);
				chk(prog_cfg_space, pg[0]);
				chk(prog_rd, op == agu_ext_pkg::TOP_READ_LOW || op == agu_ext_pkg::TOP_READ_HIGH);
				w = mem.word(w);
				@(posedge mclk);
				#1;
				if (op == agu_ext_pkg::TOP_READ_LOW) begin
					chk(rd_data & (b ? 16'h00FF : 16'hFFFF), b ? (ea[0] ? w[15:8] : w[7:0]) : w[15:0]);
				end else if (op == agu_ext_pkg::TOP_READ_HIGH) begin
					chk(rd_data & (b ? 16'h00FF : 16'hFFFF), (b && ea[0]) ? 8'h00 : w[23:16]);
				end
			end
		end
		// visibility reads: move, other, repeat edge, repeat middle, low half, disabled
		wr_reg(agu_ext_pkg::OFS_CORE_CTRL, 16'h0004);
		wr_reg(agu_ext_pkg::OFS_VIS_PAGE, 16'h00A7);
		for (int c = 0; c < 6; c++) begin
			ea = 16'(rnd()) | 16'h8000;
			ea[15] = (c != 4);
			if (c == 5) wr_reg(agu_ext_pkg::OFS_CORE_CTRL, 16'h0000);
			n = (c == 0) ? 1 : ((c == 3) ? 0 : 2);
			vis = (c < 4);
			w = mem.word({1'b0, 8'hA7, ea[14:0]});
			@(posedge mclk);
			rd_req <= '{1'b1, ea, c == 0, c == 2 || c == 3, c == 2};
			@(posedge mclk);
			rd_req.valid <= 1'b0;
			#1 chk(vis_active, vis);
			if (vis) chk(prog_addr, {1'b0, 8'hA7, ea[14:0]});
			for (int k = 0; k < 3; k++) begin
				chk(stall, vis && k < n);
				@(posedge mclk);
				#1;
				if (vis && k == 0) chk(rd_data, w[15:0]);
			end
		end
		// remap held off while a table read is taken
		wr_reg(agu_ext_pkg::OFS_CORE_CTRL, 16'h0004);
		@(posedge mclk);
		tbl_req <= '{1'b1, agu_ext_pkg::TOP_READ_LOW, 16'h8002, 1'b0};
		rd_req <= '{1'b1, 16'h8002, 1'b1, 1'b0, 1'b0};
		@(posedge mclk);
		tbl_req.valid <= 1'b0;
		#1 chk(vis_active, 1'b0);
		chk(stall, 1'b0);
		@(posedge mclk);
		rd_req.valid <= 1'b0;
		#1 chk(vis_active, 1'b0);
		chk(stall, 1'b0);
		repeat (3) @(posedge mclk);
		// five back-to-back steps of the program counter
		pc_advance <= 1'b1;
		repeat (5) @(posedge mclk);
		pc_advance <= 1'b0;
		#1 chk(pc_q_out, 24'h00000A);
		complete_run();
	end
endmodule // tb
